// ### hdl/pss_regs.vh
`ifndef PSS_REGS_VH
`define PSS_REGS_VH
// ****************************************
// register word indices (byte address = 4 * index)
// ****************************************
`define PSS_IDX_BASIC_STATUS   8'h01
`define PSS_IDX_AN_EXPANSION   8'h06
`define PSS_IDX_SUMMARY        8'h10
`define PSS_IDX_INT_STATUS     8'h12
`define PSS_IDX_FALSE_CARRIER  8'h14
`define PSS_IDX_EVT_STATUS     8'h20
`define PSS_IDX_EVT_ENABLE     8'h21
`define PSS_IDX_EVT_CLEAR      8'h22
// ****************************************
// summary field positions
// ****************************************
`define PSS_BIT_FALSE_CARRIER  11
`define PSS_BIT_SIGNAL_DETECT  10
`define PSS_BIT_DESCR_LOCK     9
`define PSS_BIT_PAGE_RX        8
`define PSS_BIT_INT_PENDING    7
`define PSS_BIT_REMOTE_FAULT   6
`define PSS_BIT_JABBER         5
`define PSS_BIT_AN_DONE        4
`define PSS_BIT_LOOPBACK       3
`define PSS_BIT_DUPLEX         2
`define PSS_BIT_SPEED10        1
`define PSS_BIT_LINK           0
`define PSS_SUMMARY_RESET      12'h000
`define PSS_EVT_RESET          4'h0
`endif

// ### hdl/pss_status.v
`timescale 1ns/100ps
`include "pss_regs.vh"
module pss_status (
    clk,
    rst_b,
    ce,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_readdata,
    avs_waitrequest,
    false_carrier_evt,
    signal_detect,
    descr_lock,
    page_rx_evt,
    int_pending_evt,
    remote_fault_evt,
    jabber,
    an_done,
    loopback_en,
    full_duplex,
    speed10,
    link_up,
    irq
);
    input  wire        clk;
    input  wire        rst_b;
    input  wire        ce;
    input  wire [7:0]  avs_address;
    input  wire        avs_read;
    input  wire        avs_write;
    input  wire [31:0] avs_writedata;
    output reg  [31:0] avs_readdata;
    output reg         avs_waitrequest;
    input  wire        false_carrier_evt;
    input  wire        signal_detect;
    input  wire        descr_lock;
    input  wire        page_rx_evt;
    input  wire        int_pending_evt;
    input  wire        remote_fault_evt;
    input  wire        jabber;
    input  wire        an_done;
    input  wire        loopback_en;
    input  wire        full_duplex;
    input  wire        speed10;
    input  wire        link_up;
    output reg         irq;

    // ****************************************
    // input synchronisers
    // ****************************************
    reg  [11:0] sync1_reg;
    reg  [11:0] sync2_reg;
    wire [11:0] raw_in;
    assign raw_in = {false_carrier_evt, signal_detect, descr_lock, page_rx_evt,
                     int_pending_evt, remote_fault_evt, jabber, an_done,
                     loopback_en, full_duplex, speed10, link_up};
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 12'h000;
            sync2_reg <= 12'h000;
        end else if (ce) begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire s_fc    = sync2_reg[11];
    wire s_sd    = sync2_reg[10];
    wire s_lock  = sync2_reg[9];
    wire s_page  = sync2_reg[8];
    wire s_int   = sync2_reg[7];
    wire s_rf    = sync2_reg[6];

    // ****************************************
    // bus decode
    // ****************************************
    // one wait cycle: request taken when waitrequest is low
    wire        acc     = (avs_read | avs_write) & ~avs_waitrequest;
    wire        rd_acc  = acc & avs_read;
    wire        wr_acc  = acc & avs_write;
    wire        rd_sum  = rd_acc && (avs_address == `PSS_IDX_SUMMARY);
    wire        rd_fc   = rd_acc && (avs_address == `PSS_IDX_FALSE_CARRIER);
    wire        rd_anx  = rd_acc && (avs_address == `PSS_IDX_AN_EXPANSION);
    wire        rd_isr  = rd_acc && (avs_address == `PSS_IDX_INT_STATUS);
    wire        rd_bsr  = rd_acc && (avs_address == `PSS_IDX_BASIC_STATUS);

    // ****************************************
    // latched fields (a new event wins over a read)
    // ****************************************
    reg         fc_reg;
    reg         sd_reg;
    reg         lock_reg;
    reg         page_reg;
    reg         intp_reg;
    reg         rf_reg;
    reg  [5:0]  live_reg;
    reg         sd_seen_reg;
    reg         lock_seen_reg;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fc_reg        <= 1'b0;
            sd_reg        <= 1'b0;
            lock_reg      <= 1'b0;
            page_reg      <= 1'b0;
            intp_reg      <= 1'b0;
            rf_reg        <= 1'b0;
            live_reg      <= 6'h00;
            sd_seen_reg   <= 1'b0;
            lock_seen_reg <= 1'b0;
        end else if (ce) begin
            fc_reg   <= s_fc | (fc_reg & ~rd_fc);
            page_reg <= s_page | (page_reg & ~rd_anx);
            intp_reg <= s_int | (intp_reg & ~rd_isr);
            rf_reg   <= s_rf | (rf_reg & ~rd_bsr);
            // latched-low: a drop sticks until a summary read refreshes it
            if (!s_sd)
                sd_reg <= 1'b0;
            else if (rd_sum || !sd_seen_reg)
                sd_reg <= 1'b1;
            if (!s_sd)
                sd_seen_reg <= 1'b1;
            else if (rd_sum)
                sd_seen_reg <= 1'b0;
            if (!s_lock)
                lock_reg <= 1'b0;
            else if (rd_sum || !lock_seen_reg)
                lock_reg <= 1'b1;
            if (!s_lock)
                lock_seen_reg <= 1'b1;
            else if (rd_sum)
                lock_seen_reg <= 1'b0;
            live_reg <= sync2_reg[5:0];
        end
    end

    wire [11:0] summary = {fc_reg, sd_reg, lock_reg, page_reg, intp_reg, rf_reg,
                           live_reg};

    // ****************************************
    // event interrupt bank
    // ****************************************
    reg  [3:0]  evt_reg;
    reg  [3:0]  en_reg;
    wire [3:0]  evt_set = {s_fc, s_page, s_int, s_rf};
    wire        wr_clr  = wr_acc && (avs_address == `PSS_IDX_EVT_CLEAR);
    wire        wr_en   = wr_acc && (avs_address == `PSS_IDX_EVT_ENABLE);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_reg <= `PSS_EVT_RESET;
            en_reg  <= `PSS_EVT_RESET;
            irq     <= 1'b0;
        end else if (ce) begin
            evt_reg <= evt_set | (evt_reg & ~(wr_clr ? avs_writedata[3:0] : 4'h0));
            if (wr_en)
                en_reg <= avs_writedata[3:0];
            irq <= |(evt_reg & en_reg);
        end
    end

    // ****************************************
    // bus answer
    // ****************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (ce) begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if ((avs_read | avs_write) & avs_waitrequest) begin
                // writes to summary are dropped; unmapped reads return zero
                case (avs_address)
                    `PSS_IDX_SUMMARY:    avs_readdata <= {20'h00000, summary};
                    `PSS_IDX_EVT_STATUS: avs_readdata <= {28'h0000000, evt_reg};
                    `PSS_IDX_EVT_ENABLE: avs_readdata <= {28'h0000000, en_reg};
                    default:             avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ### verification/pss_status_asserts.sv
`timescale 1ns/100ps
module pss_status_asserts (
    input wire        clk,
    input wire        rst_b,
    input wire        ce,
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        jabber,
    input wire        an_done,
    input wire        loopback_en,
    input wire        full_duplex,
    input wire        speed10,
    input wire        link_up,
    input wire        irq
);
    // ****
    // level fields need 5 settled cycles: 2 sync flops plus field and read registers
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire sum_rd = ce && avs_read && !avs_waitrequest && avs_address == 8'h10;
    AST_TAKE: assert property (ce && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    AST_ONE_LOW: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_UPPER: assert property (sum_rd |-> avs_readdata[31:12] == 20'h0)
        else $error("upper summary bits set");
    AST_LINK: assert property (link_up[*5] ##0 sum_rd |-> avs_readdata[0])
        else $error("link field wrong");
    AST_SPEED: assert property (!speed10[*5] ##0 sum_rd |-> !avs_readdata[1])
        else $error("speed field wrong");
    AST_DUPLEX: assert property (full_duplex[*5] ##0 sum_rd |-> avs_readdata[2])
        else $error("duplex field wrong");
    AST_LOOP: assert property (!loopback_en[*5] ##0 sum_rd |-> !avs_readdata[3])
        else $error("loopback field wrong");
    AST_AN: assert property (an_done[*5] ##0 sum_rd |-> avs_readdata[4])
        else $error("autoneg field wrong");
    AST_JAB: assert property (jabber[*5] ##0 sum_rd |-> avs_readdata[5])
        else $error("jabber field wrong");
    cover property (sum_rd && avs_readdata[11]);
    cover property (irq);
    cover property (ce && avs_write && !avs_waitrequest);
endmodule

// ### verification/pss_status_test.sv
`timescale 1ns/100ps
module pss_status_test;
    reg clk = 0, rst_b = 0, ce = 1, rd = 0, wr = 0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wd = 32'h0, d, e;
    reg fc = 0, sd = 0, dl = 0, pg = 0, ip = 0, rf = 0, jb = 0, an = 0, lb = 0, fd = 0, sp = 0, lk = 0;
    wire [31:0] rdata;
    wire wait_req, irq;
    int miscompares = 0, n_checks = 0, i;
    reg [7:0] src [4] = '{8'h14, 8'h06, 8'h12, 8'h01};
    int fb [4] = '{11, 8, 7, 6};
    always #5 clk = ~clk;
    pss_status DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_req),
        .false_carrier_evt(fc), .signal_detect(sd), .descr_lock(dl), .page_rx_evt(pg),
        .int_pending_evt(ip), .remote_fault_evt(rf), .jabber(jb), .an_done(an),
        .loopback_en(lb), .full_duplex(fd), .speed10(sp), .link_up(lk), .irq(irq));
    // ****
    // bus tasks: hold request until waitrequest sampled low
    // ****
    task bus(input [7:0] a, input w, input [31:0] v);
        adr <= a; wd <= v; rd <= !w; wr <= w;
        do @(posedge clk); while (wait_req !== 1'b0);
        d = rdata; rd <= 0; wr <= 0;
        @(posedge clk);
    endtask
    task chk(input [31:0] s, input [31:0] x);
        n_checks++;
        if (s !== x) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task rchk(input [7:0] a, input [31:0] x);
        bus(a, 0, 0); chk(d, x);
    endtask
    task conclude;
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000; miscompares++; conclude;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1; @(posedge clk);
        rchk(8'h10, 32'h0);
        bus(8'h10, 1, 32'hffff); rchk(8'h10, 32'h0);
        rchk(8'h3f, 32'h0);
        $display("reset and write test done");
        {sd, dl, jb, an, lb, fd, sp, lk} <= 8'hff; repeat (6) @(posedge clk);
        // low levels seen since reset stay latched until the first summary read
        rchk(8'h10, 32'h03f);
        rchk(8'h10, 32'h63f);
        {sd, dl} <= 2'b00; @(posedge clk); {sd, dl} <= 2'b11; repeat (6) @(posedge clk);
        rchk(8'h10, 32'h03f); rchk(8'h10, 32'h63f);
        {sp, lb} <= 2'b00; repeat (6) @(posedge clk); rchk(8'h10, 32'h635);
        $display("level field test done");
        {fc, pg, ip, rf} <= 4'hf; @(posedge clk); {fc, pg, ip, rf} <= 4'h0;
        repeat (6) @(posedge clk); e = 32'hff5;
        rchk(8'h10, e); rchk(8'h10, e);
        for (i = 0; i < 4; i++) begin
            bus(src[i], 0, 0); e[fb[i]] = 1'b0; rchk(8'h10, e);
        end
        $display("event field test done");
        rchk(8'h20, 32'hf); chk(irq, 0);
        bus(8'h21, 1, 32'h1); rchk(8'h21, 32'h1); repeat (3) @(posedge clk); chk(irq, 1);
        bus(8'h22, 1, 32'h1); repeat (3) @(posedge clk); chk(irq, 0); rchk(8'h20, 32'he);
        bus(8'h21, 1, 32'h2); repeat (3) @(posedge clk); chk(irq, 1);
        bus(8'h21, 1, 32'h0); repeat (3) @(posedge clk); chk(irq, 0);
        $display("interrupt test done");
        conclude;
    end
endmodule
bind pss_status pss_status_asserts CHK (.*);
